// ===== epfap_defs.svh
// register offsets, reset values and timing counts of the endpoint fifo access port
`ifndef EPFAP_DEFS_SVH
`define EPFAP_DEFS_SVH
`define EPFAP_OFS_LEN 8'h1c
`define EPFAP_OFS_STAT 8'h1e
`define EPFAP_OFS_DATA 8'h20
`define EPFAP_LEN_RST 16'h0000
`define EPFAP_STAT_RST 2'b00
`define EPFAP_WORD_BYTES 16'h0002
`define EPFAP_CTRL_EP 0
`define EPFAP_CLK_PERIOD_NS 10
`define EPFAP_IDX_TO_RD_NS 190
`define EPFAP_IDX_TO_WR_NS 100
`define EPFAP_TO_STAT_NS 200
`define EPFAP_IDX_TO_RD_CYC ((`EPFAP_IDX_TO_RD_NS + `EPFAP_CLK_PERIOD_NS - 1) / `EPFAP_CLK_PERIOD_NS)
`define EPFAP_IDX_TO_WR_CYC ((`EPFAP_IDX_TO_WR_NS + `EPFAP_CLK_PERIOD_NS - 1) / `EPFAP_CLK_PERIOD_NS)
`define EPFAP_TO_STAT_CYC ((`EPFAP_TO_STAT_NS + `EPFAP_CLK_PERIOD_NS - 1) / `EPFAP_CLK_PERIOD_NS)
`endif

// ===== epfap_pkg.sv
// types shared by the endpoint fifo access port
package epfap_pkg;
  typedef logic [15:0] epfap_word_t;
  // one-hot register select of the processor port
  typedef enum logic [3:0] {
    EPFAP_SEL_NONE = 4'b0001,
    EPFAP_SEL_LEN = 4'b0010,
    EPFAP_SEL_STAT = 4'b0100,
    EPFAP_SEL_DATA = 4'b1000
  } epfap_sel_e;
endpackage : epfap_pkg

// ===== epfap_ep_ctx.sv
// per-endpoint buffer bookkeeping: pointers, fill bits, lengths and byte count
`timescale 1ns/10ps
`default_nettype none
`include "epfap_defs.svh"
module epfap_ep_ctx
  import epfap_pkg::*;
#(
  parameter int PW = 11
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_reset,
  input wire logic dir_in,
  input wire logic dbl_en,
  input wire logic dma_mode,
  input wire logic cpu_push,
  input wire logic cpu_pop,
  input wire logic mps_load,
  input wire logic [PW-1:0] mps_val,
  input wire logic len_wr,
  input wire epfap_word_t len_val,
  input wire logic force_validate,
  input wire logic force_discard,
  input wire logic sie_out_wr,
  input wire logic sie_out_ack,
  input wire epfap_word_t sie_out_len,
  input wire logic sie_in_done,
  output logic [PW-1:0] cpu_ptr,
  output logic cpu_buf,
  output logic [PW-1:0] sie_ptr,
  output logic sie_buf,
  output logic [1:0] fill,
  output epfap_word_t byte_count,
  output epfap_word_t cpu_len,
  output epfap_word_t sie_len
);
  // processor pointer arithmetic runs in the 16-bit byte count domain
  if (PW < 2 || PW > 16) begin : g_bad_pw
    $error("epfap_ep_ctx: PW must lie within 2..16");
  end
  logic [PW-1:0] cpu_ptr_ff, sie_ptr_ff, mps_ff;
  logic cpu_buf_ff, sie_buf_ff;
  logic [1:0] fill_ff;
  epfap_word_t byte_count_ff;
  epfap_word_t len_ff [2];

  // in-direction packing and automatic validation
  wire epfap_word_t ptr_step = epfap_word_t'(cpu_ptr_ff) + `EPFAP_WORD_BYTES;
  wire epfap_word_t mps16 = epfap_word_t'(mps_ff);
  wire short_ok = !dma_mode && byte_count_ff != 16'h0000 && byte_count_ff < mps16;
  wire epfap_word_t in_target = short_ok ? byte_count_ff : mps16;
  wire push_ok = dir_in && cpu_push && !fill_ff[cpu_buf_ff];
  wire in_full = push_ok && ptr_step >= in_target;
  wire in_val = in_full || (dir_in && force_validate && !fill_ff[cpu_buf_ff]);
  wire epfap_word_t in_len = in_full ? ((ptr_step < in_target) ? ptr_step : in_target)
                                     : epfap_word_t'(cpu_ptr_ff);
  // out-direction unpacking: the last word read frees the buffer
  wire pop_ok = !dir_in && cpu_pop && fill_ff[cpu_buf_ff];
  wire out_done = pop_ok && ptr_step >= len_ff[cpu_buf_ff];
  // discard drops the oldest validated in packet, else the partly written one
  wire disc_in_old = dir_in && force_discard && fill_ff[sie_buf_ff];
  wire disc_in_new = dir_in && force_discard && !fill_ff[sie_buf_ff];
  wire disc_out = !dir_in && force_discard && fill_ff[cpu_buf_ff];
  wire ack_out = !dir_in && sie_out_ack && !fill_ff[sie_buf_ff];
  wire cpu_adv = in_val || out_done || disc_out;
  wire sie_adv = (dir_in && sie_in_done) || ack_out || disc_in_old;
  wire [1:0] set_mask = ({1'b0, in_val} << cpu_buf_ff) | ({1'b0, ack_out} << sie_buf_ff);
  wire [1:0] clr_mask = ({1'b0, out_done || disc_out} << cpu_buf_ff)
                      | ({1'b0, (dir_in && sie_in_done) || disc_in_old} << sie_buf_ff);
  // setting wins over clearing on the same buffer
  wire [1:0] nxt_fill = (fill_ff & ~clr_mask) | set_mask;
  wire nxt_cpu_buf = dbl_en & (cpu_buf_ff ^ cpu_adv);
  wire nxt_sie_buf = dbl_en & (sie_buf_ff ^ sie_adv);
  wire [PW-1:0] nxt_cpu_ptr = (cpu_adv || disc_in_new) ? '0
                            : (push_ok || pop_ok) ? ptr_step[PW-1:0] : cpu_ptr_ff;
  wire [PW-1:0] nxt_sie_ptr = sie_adv ? '0
                            : (sie_out_wr && !dir_in) ? sie_ptr_ff + PW'(2) : sie_ptr_ff;

  // pointer and fill state; usb bus reset empties everything
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ptr_ff <= '0;
      sie_ptr_ff <= '0;
      cpu_buf_ff <= 1'b0;
      sie_buf_ff <= 1'b0;
      fill_ff <= `EPFAP_STAT_RST;
    end else if (bus_reset) begin
      cpu_ptr_ff <= '0;
      sie_ptr_ff <= '0;
      cpu_buf_ff <= 1'b0;
      sie_buf_ff <= 1'b0;
      fill_ff <= `EPFAP_STAT_RST;
    end else begin
      cpu_ptr_ff <= nxt_cpu_ptr;
      sie_ptr_ff <= nxt_sie_ptr;
      cpu_buf_ff <= nxt_cpu_buf;
      sie_buf_ff <= nxt_sie_buf;
      fill_ff <= nxt_fill;
    end
  end

  // packet lengths and the byte count register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mps_ff <= '0;
      byte_count_ff <= `EPFAP_LEN_RST;
      len_ff[0] <= '0;
      len_ff[1] <= '0;
    end else begin
      if (mps_load) mps_ff <= mps_val;
      if (bus_reset) byte_count_ff <= `EPFAP_LEN_RST;
      else if (ack_out) byte_count_ff <= sie_out_len;
      else if (mps_load) byte_count_ff <= epfap_word_t'(mps_val);
      else if (len_wr) byte_count_ff <= len_val;
      if (in_val) len_ff[cpu_buf_ff] <= in_len;
      if (ack_out) len_ff[sie_buf_ff] <= sie_out_len;
    end
  end

  assign cpu_ptr = cpu_ptr_ff;
  assign cpu_buf = cpu_buf_ff;
  assign sie_ptr = sie_ptr_ff;
  assign sie_buf = sie_buf_ff;
  assign fill = fill_ff;
  assign byte_count = byte_count_ff;
  assign cpu_len = len_ff[cpu_buf_ff];
  assign sie_len = len_ff[sie_buf_ff];
endmodule : epfap_ep_ctx
`default_nettype wire

// ===== epfap_top.sv
// endpoint fifo access port: indexed word window, byte count and fill status
`timescale 1ns/10ps
`default_nettype none
`include "epfap_defs.svh"
module epfap_top
  import epfap_pkg::*;
#(
  parameter int NUM_EP = 8,
  parameter int FIFO_BYTES = 1024,
  parameter int IW = $clog2(NUM_EP),
  parameter int PW = $clog2(FIFO_BYTES) + 1,
  parameter int DW = $clog2(FIFO_BYTES / 2)
) (
  // clock and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_reset,
  // processor register port
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire epfap_word_t bus_wdata,
  output epfap_word_t bus_rdata,
  // fields of neighbouring endpoint registers
  input wire logic [IW-1:0] ep_index,
  input wire logic [NUM_EP-1:0] ep_dir_in,
  input wire logic [NUM_EP-1:0] ep_dbl_en,
  input wire logic dma_mode,
  input wire logic mps_wr,
  input wire logic [PW-1:0] mps_val,
  // control bits aimed at the indexed endpoint
  input wire logic force_validate,
  input wire logic force_discard,
  // usb engine side of the buffers
  input wire logic [IW-1:0] sie_ep,
  input wire logic sie_out_wr,
  input wire epfap_word_t sie_out_data,
  input wire logic sie_out_ack,
  input wire epfap_word_t sie_out_len,
  input wire logic sie_in_done,
  input wire logic [DW-1:0] sie_rd_idx,
  output epfap_word_t sie_rd_data,
  output epfap_word_t sie_in_len,
  output logic sie_in_ready
);
  // refuse sizes that the pointer and word slot arithmetic cannot serve
  if (NUM_EP < 2 || (1 << IW) != NUM_EP || FIFO_BYTES < 4 || FIFO_BYTES > 2048
      || (1 << DW) != FIFO_BYTES / 2 || PW != $clog2(FIFO_BYTES) + 1) begin : g_bad_cfg
    $error("epfap_top: NUM_EP and FIFO_BYTES must be powers of two, FIFO_BYTES 4..2048");
  end

  // byte pointer to word slot in the endpoint buffer
  function automatic logic [DW-1:0] word_slot(input logic [PW-1:0] ptr);
    word_slot = ptr[DW:1];
  endfunction : word_slot

  // index compare, shared by the processor and usb side steering
  function automatic logic ep_hit(input logic [IW-1:0] idx, input int unsigned ep);
    ep_hit = idx == IW'(ep);
  endfunction : ep_hit

  // two buffers per endpoint, one word per slot
  epfap_word_t mem [NUM_EP][2][FIFO_BYTES/2];
  // output flops
  epfap_word_t bus_rdata_ff, sie_rd_data_ff, sie_in_len_ff;
  logic sie_in_ready_ff;

  // per-endpoint state gathered from the bookkeeping instances
  logic [PW-1:0] cpu_ptr [NUM_EP];
  logic [PW-1:0] sie_ptr [NUM_EP];
  logic [NUM_EP-1:0] cpu_buf, sie_buf;
  logic [1:0] fill [NUM_EP];
  epfap_word_t byte_count [NUM_EP];
  epfap_word_t cpu_len [NUM_EP];
  epfap_word_t sie_len [NUM_EP];

  // register decode of the processor port
  wire at_len = bus_addr == `EPFAP_OFS_LEN;
  wire at_stat = bus_addr == `EPFAP_OFS_STAT;
  wire at_data = bus_addr == `EPFAP_OFS_DATA;
  // one-hot select; anything else is unmapped and reads zero
  wire epfap_sel_e sel = at_len ? EPFAP_SEL_LEN
                       : at_stat ? EPFAP_SEL_STAT
                       : at_data ? EPFAP_SEL_DATA : EPFAP_SEL_NONE;
  wire data_wr = bus_wr && sel == EPFAP_SEL_DATA;
  wire data_rd = bus_rd && sel == EPFAP_SEL_DATA;
  wire len_wr = bus_wr && sel == EPFAP_SEL_LEN;

  // per-endpoint bookkeeping, strobes steered by the index
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep
    wire hit = ep_hit(ep_index, i);
    // the usb engine addresses its own endpoint, so both sides work at once
    wire sie_hit = ep_hit(sie_ep, i);
    epfap_ep_ctx #(.PW(PW)) u_ctx (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .bus_reset(bus_reset),
      .dir_in(ep_dir_in[i]),
      .dbl_en(ep_dbl_en[i]),
      .dma_mode(dma_mode),
      .cpu_push(hit && data_wr),
      .cpu_pop(hit && data_rd),
      .mps_load(hit && mps_wr),
      .mps_val(mps_val),
      .len_wr(hit && len_wr),
      .len_val(bus_wdata),
      .force_validate(hit && force_validate),
      .force_discard(hit && force_discard),
      .sie_out_wr(sie_hit && sie_out_wr),
      .sie_out_ack(sie_hit && sie_out_ack),
      .sie_out_len(sie_out_len),
      .sie_in_done(sie_hit && sie_in_done),
      .cpu_ptr(cpu_ptr[i]),
      .cpu_buf(cpu_buf[i]),
      .sie_ptr(sie_ptr[i]),
      .sie_buf(sie_buf[i]),
      .fill(fill[i]),
      .byte_count(byte_count[i]),
      .cpu_len(cpu_len[i]),
      .sie_len(sie_len[i])
    );
  end

  // indexed views of the selected endpoint
  wire [PW-1:0] sel_ptr = cpu_ptr[ep_index];
  wire sel_buf = cpu_buf[ep_index];
  wire sel_dir_in = ep_dir_in[ep_index];
  wire sel_filled = fill[ep_index][sel_buf];
  wire [DW-1:0] cpu_slot = word_slot(sel_ptr);
  // bytes left in the buffer being drained, counted from the read pointer
  wire epfap_word_t remain = cpu_len[ep_index] - epfap_word_t'(sel_ptr);
  wire epfap_word_t rd_word = mem[ep_index][sel_buf][cpu_slot];
  // a lone final byte sits in the low lane, high lane reads zero
  wire epfap_word_t port_word = (remain == 16'h0001) ? {8'h00, rd_word[7:0]} : rd_word;
  wire is_ctrl = ep_hit(ep_index, `EPFAP_CTRL_EP);
  // control endpoint has no double buffer, so its fill state reads zero
  wire [1:0] stat_bits = is_ctrl ? `EPFAP_STAT_RST : fill[ep_index];

  // read sources of the three mapped registers
  wire epfap_word_t len_word = byte_count[ep_index];
  wire epfap_word_t stat_word = {14'h0000, stat_bits};
  // in endpoints and empty out buffers read zero, so a stray read moves nothing
  wire data_ok = !sel_dir_in && sel_filled;
  wire epfap_word_t data_word = data_ok ? port_word : 16'h0000;
  wire epfap_word_t rd_mux = (sel == EPFAP_SEL_LEN) ? len_word
                           : (sel == EPFAP_SEL_STAT) ? stat_word
                           : (sel == EPFAP_SEL_DATA) ? data_word
                           : 16'h0000;
  // idle cycles return zero so a late sample never sees stale data
  wire epfap_word_t nxt_bus_rdata = bus_rd ? rd_mux : 16'h0000;

  // storage write ports; direction keeps them apart, in buffers belong to the processor
  wire cpu_store = data_wr && sel_dir_in && !sel_filled;
  wire sie_store = sie_out_wr && !ep_dir_in[sie_ep];
  wire sie_sbuf = sie_buf[sie_ep];
  wire [DW-1:0] sie_slot = word_slot(sie_ptr[sie_ep]);

  // fifo storage: processor fills in buffers, usb engine fills out buffers
  // no reset on the array: contents only count once a fill bit vouches for them
  always_ff @(posedge sys_clk) begin
    if (cpu_store) mem[ep_index][sel_buf][cpu_slot] <= bus_wdata;
    if (sie_store) mem[sie_ep][sie_sbuf][sie_slot] <= sie_out_data;
  end

  // registered read data; unmapped addresses and idle cycles read zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata_ff <= '0;
    end else begin
      bus_rdata_ff <= nxt_bus_rdata;
    end
  end

  // usb side view of the buffer due for transmission
  wire sie_dir_in = ep_dir_in[sie_ep];
  wire [1:0] sie_fill = fill[sie_ep];
  wire epfap_word_t sie_word = mem[sie_ep][sie_sbuf][sie_rd_idx];
  wire epfap_word_t sie_buf_len = sie_len[sie_ep];
  // ready only once the buffer is validated, the length is final by then
  wire sie_ready = sie_dir_in && sie_fill[sie_sbuf];

  // registered so the usb engine sees every output straight from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sie_rd_data_ff <= '0;
      sie_in_len_ff <= '0;
      sie_in_ready_ff <= 1'b0;
    end else begin
      sie_rd_data_ff <= sie_word;
      sie_in_len_ff <= sie_buf_len;
      sie_in_ready_ff <= sie_ready;
    end
  end

  // outputs come straight from their flops
  assign bus_rdata = bus_rdata_ff;
  assign sie_rd_data = sie_rd_data_ff;
  assign sie_in_len = sie_in_len_ff;
  assign sie_in_ready = sie_in_ready_ff;
endmodule : epfap_top
`default_nettype wire

// ===== epfap_top_chk.sv
// port assertions of the endpoint fifo access port
`timescale 1ns/10ps
`default_nettype none
module epfap_top_chk
  import epfap_pkg::*;
#(
  parameter int NUM_EP = 8,
  parameter int IW = 3,
  parameter int PW = 11
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic bus_reset,
  input wire logic [7:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire epfap_word_t bus_wdata,
  input wire epfap_word_t bus_rdata,
  input wire logic [IW-1:0] ep_index,
  input wire logic [NUM_EP-1:0] ep_dir_in,
  input wire logic mps_wr,
  input wire logic [PW-1:0] mps_val,
  input wire logic sie_out_ack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // gap cycle must hold no other writer of the byte count, else the readback is ambiguous
  wire logic still = !bus_reset && !sie_out_ack && !mps_wr && !bus_wr;
  wire logic mapped = bus_addr == 8'h1c || bus_addr == 8'h1e || bus_addr == 8'h20;
  sequence rd_of(logic [7:0] a);
    bus_rd && bus_addr == a;
  endsequence
  sequence gap_rd;
    still ##0 $stable(ep_index) ##1 rd_of(8'h1c) ##0 $stable(ep_index);
  endsequence
  AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (bus_rd && !mapped |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_STAT_HIGH: assert property (rd_of(8'h1e) |=> bus_rdata[15:2] == 14'h0000)
    else $error("fill status upper bits set");
  AST_STAT_CTRL: assert property (rd_of(8'h1e) ##0 ep_index == '0 |=> bus_rdata == 16'h0000)
    else $error("fill status on control endpoint");
  AST_IN_RD_ZERO: assert property (rd_of(8'h20) ##0 ep_dir_in[ep_index] |=> bus_rdata == 16'h0000)
    else $error("data read on in endpoint");
  AST_LEN_RW: assert property ((bus_wr && bus_addr == 8'h1c && !bus_reset && !sie_out_ack && !mps_wr)
    ##1 gap_rd |=> bus_rdata == $past(bus_wdata, 3))
    else $error("byte count readback wrong");
  AST_MPS_LOAD: assert property ((mps_wr && !bus_reset && !sie_out_ack && !bus_wr) ##1 gap_rd
    |=> bus_rdata == 16'($past(mps_val, 3)))
    else $error("byte count not reloaded");
  AST_RESET_LEN: assert property (bus_reset ##1 gap_rd |=> bus_rdata == 16'h0000)
    else $error("byte count kept over bus reset");
endmodule : epfap_top_chk
bind epfap_top epfap_top_chk #(.NUM_EP(NUM_EP), .IW(IW), .PW(PW)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus_reset(bus_reset), .bus_addr(bus_addr),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
  .ep_index(ep_index), .ep_dir_in(ep_dir_in), .mps_wr(mps_wr), .mps_val(mps_val),
  .sie_out_ack(sie_out_ack)
);
`default_nettype wire

// ===== epfap_cpu_model.sv
// processor model: endpoint index and register port cycles
`timescale 1ns/10ps
`default_nettype none
`include "epfap_defs.svh"
module epfap_cpu_model
  import epfap_pkg::*;
(
  input wire logic sys_clk,
  input wire epfap_word_t bus_rdata,
  output logic [7:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output epfap_word_t bus_wdata,
  output logic [2:0] ep_index
);
  // bus idle at time zero
  initial {bus_addr, bus_wr, bus_rd, bus_wdata, ep_index} = '0;
  // new index, then the longer data port wait covers reads and writes alike
  task automatic sel(input logic [2:0] ep);
    @(negedge sys_clk);
    ep_index = ep;
    repeat (`EPFAP_IDX_TO_RD_CYC) @(negedge sys_clk);
  endtask : sel
  // one strobe cycle; released address and data lines show the inverse, not a stale copy, and both strobes drop to zero
  task automatic acc(input logic w, input logic [7:0] a, input epfap_word_t d,
                     output epfap_word_t q);
    @(negedge sys_clk);
    {bus_addr, bus_wr, bus_rd, bus_wdata} = {a, w, !w, d};
    @(negedge sys_clk);
    q = bus_rdata;
    {bus_addr, bus_wr, bus_rd, bus_wdata} = {~a, 2'b00, ~d};
  endtask : acc
endmodule : epfap_cpu_model
`default_nettype wire

// ===== test_epfap_top.sv
// self-checking bench of the endpoint fifo access port
`timescale 1ns/10ps
`default_nettype none
`include "epfap_defs.svh"
module test_epfap_top
  import epfap_pkg::*;
;
  logic sys_clk, rst_n, bus_reset, bus_wr, bus_rd, dma_mode, mps_wr;
  logic force_validate, force_discard, sie_out_wr, sie_out_ack, sie_in_done, sie_in_ready;
  logic [7:0] bus_addr, ep_dir_in, ep_dbl_en;
  logic [2:0] ep_index, sie_ep;
  logic [10:0] mps_val;
  logic [8:0] sie_rd_idx;
  epfap_word_t bus_wdata, bus_rdata, sie_out_data, sie_out_len, sie_rd_data, sie_in_len, q;
  epfap_word_t w[4];
  int errors, tests_run, n;
  int lens[2] = '{8, 5};
  int olen[3] = '{5, 4, 6};
  epfap_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_reset(bus_reset), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .ep_index(ep_index), .ep_dir_in(ep_dir_in), .ep_dbl_en(ep_dbl_en), .dma_mode(dma_mode),
    .mps_wr(mps_wr), .mps_val(mps_val), .force_validate(force_validate),
    .force_discard(force_discard), .sie_ep(sie_ep), .sie_out_wr(sie_out_wr),
    .sie_out_data(sie_out_data), .sie_out_ack(sie_out_ack), .sie_out_len(sie_out_len),
    .sie_in_done(sie_in_done), .sie_rd_idx(sie_rd_idx), .sie_rd_data(sie_rd_data),
    .sie_in_len(sie_in_len), .sie_in_ready(sie_in_ready));
  epfap_cpu_model cpu (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .ep_index(ep_index));
  // odd packets carry only the low byte in their last word
  function automatic epfap_word_t last_word(epfap_word_t x, int len);
    return len[0] ? {8'h00, x[7:0]} : x;
  endfunction : last_word
  task automatic chk(input epfap_word_t got, input epfap_word_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask : pulse
  task automatic rdc(input logic [7:0] a, input epfap_word_t e);
    cpu.acc(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask : rdc
  task automatic wait_stat;
    repeat (`EPFAP_TO_STAT_CYC) @(negedge sys_clk);
  endtask : wait_stat
  // free-running clock and a watchdog far beyond the expected run
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  // main sequence: idle, in packets, dma, double buffer, out packets, bus reset
  initial begin
    {rst_n, bus_reset, dma_mode, mps_wr, force_validate, force_discard} = '0;
    {sie_out_wr, sie_out_ack, sie_in_done, sie_ep, sie_rd_idx, mps_val} = '0;
    {sie_out_data, sie_out_len, ep_dir_in, ep_dbl_en} = {32'h0, 8'h06, 8'h04};
    void'($urandom(49539));
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    rdc(8'h1e, 16'h0000);
    cpu.sel(3'h1);
    rdc(8'h1c, 16'h0000);
    rdc(8'h10, 16'h0000);
    rdc(8'h20, 16'h0000);
    w[0] = 16'($urandom);
    cpu.acc(1'b1, 8'h1c, w[0], q);
    rdc(8'h1c, w[0]);
    mps_val = 11'h008;
    pulse(mps_wr);
    rdc(8'h1c, 16'h0008);
    sie_ep = 3'h1;
    foreach (lens[k]) begin
      cpu.acc(1'b1, 8'h1c, 16'(lens[k]), q);
      for (int i = 0; i < (lens[k] + 1) / 2; i++) begin
        w[i] = 16'($urandom);
        cpu.acc(1'b1, 8'h20, w[i], q);
      end
      wait_stat();
      rdc(8'h1e, 16'h0001);
      for (int i = 0; i < (lens[k] + 1) / 2; i++) begin
        @(negedge sys_clk);
        sie_rd_idx = 9'(i);
        @(negedge sys_clk);
        chk(sie_rd_data, w[i]);
      end
      chk(sie_in_len, 16'(lens[k]));
      chk({15'h0000, sie_in_ready}, 16'h0001);
      pulse(sie_in_done);
      repeat (3) @(negedge sys_clk);
      chk({15'h0000, sie_in_ready}, 16'h0000);
    end
    dma_mode = 1'b1;
    cpu.acc(1'b1, 8'h1c, 16'h0003, q);
    cpu.acc(1'b1, 8'h20, 16'($urandom), q);
    cpu.acc(1'b1, 8'h20, 16'($urandom), q);
    wait_stat();
    rdc(8'h1e, 16'h0000);
    pulse(force_validate);
    wait_stat();
    rdc(8'h1e, 16'h0001);
    chk(sie_in_len, 16'h0004);
    pulse(sie_in_done);
    dma_mode = 1'b0;
    cpu.sel(3'h2);
    mps_val = 11'h004;
    pulse(mps_wr);
    for (int i = 0; i < 4; i++) cpu.acc(1'b1, 8'h20, 16'($urandom), q);
    wait_stat();
    rdc(8'h1e, 16'h0003);
    pulse(force_discard);
    rdc(8'h1e, 16'h0002);
    pulse(force_discard);
    rdc(8'h1e, 16'h0000);
    cpu.sel(3'h3);
    sie_ep = 3'h3;
    foreach (olen[k]) begin
      n = (olen[k] + 1) / 2;
      for (int i = 0; i < n; i++) begin
        w[i] = 16'($urandom);
        @(negedge sys_clk);
        {sie_out_wr, sie_out_data} = {1'b1, w[i]};
      end
      @(negedge sys_clk);
      {sie_out_wr, sie_out_ack, sie_out_len} = {2'b01, 16'(olen[k])};
      @(negedge sys_clk);
      sie_out_ack = 1'b0;
      wait_stat();
      rdc(8'h1c, 16'(olen[k]));
      rdc(8'h1e, 16'h0001);
      for (int i = 0; i < ((k == 2) ? 1 : n); i++) begin
        rdc(8'h20, (i == n - 1) ? last_word(w[i], olen[k]) : w[i]);
      end
      if (k == 2) pulse(force_discard);
      rdc(8'h1e, 16'h0000);
      rdc(8'h20, 16'h0000);
    end
    cpu.acc(1'b1, 8'h1c, 16'($urandom_range(1, 16'hffff)), q);
    pulse(bus_reset);
    rdc(8'h1c, 16'h0000);
    print_verdict();
  end
endmodule : test_epfap_top
`default_nettype wire
